// [octet_buffer.sv]
`timescale 1ns/1ns
`default_nettype none
// small fifo; a receiver stall fills it and then holds the source
module octet_buffer #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    // clock, reset, enable
    input  wire logic     clk_i,
    input  wire logic     rst_i,
    input  wire logic     ce_i,
    // streams
    octet_stream_if.snk   push,
    octet_stream_if.src   pop
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [W+1:0]  mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          do_push;
    logic          do_pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign push.ready = ce_i && (count != FULL_CNT);
    assign pop.valid  = (count != '0);
    assign do_push    = push.valid && push.ready;
    assign do_pop     = ce_i && pop.valid && pop.ready;
    // read side comes straight out of the storage flops
    assign {pop.conn, pop.last, pop.data} = mem[rd_ptr];

    // storage write
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr] <= {push.conn, push.last, push.data};
        end
    end

    // pointers and fill level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

// [octet_stream_if.sv]
`timescale 1ns/1ns
`default_nettype none
// one octet per beat, with end-of-frame and connect-primitive tags
interface octet_stream_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic         last;
    logic         conn;
    logic         valid;
    logic         ready;
    modport src (output data, output last, output conn, output valid,
                 input ready);
    modport snk (input data, input last, input conn, input valid,
                 output ready);
endinterface
`default_nettype wire

// [secure_frame_codec.sv]
`timescale 1ns/1ns
`default_nettype none
module secure_frame_codec
    import sfc_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    // clock, reset, enable
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    // apb slave
    input  wire logic [7:0]  PADDR_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // frame body from local control
    input  wire logic [7:0]  TX_DATA_I,
    input  wire logic        TX_VALID_I,
    input  wire logic        TX_LAST_I,
    input  wire logic        TX_PRIO_I,
    output logic             TX_READY_O,
    // framed octets to transport
    output logic [7:0]       OUT_DATA_O,
    output logic             OUT_LAST_O,
    output logic             OUT_CONN_O,
    output logic             OUT_VALID_O,
    input  wire logic        OUT_READY_I,
    // framed octets from transport
    input  wire logic [7:0]  RX_DATA_I,
    input  wire logic        RX_VALID_I,
    input  wire logic        RX_LAST_I,
    input  wire logic        RX_PRIO_I,
    output logic             RX_READY_O,
    // parsed body to local control
    output logic [7:0]       USR_DATA_O,
    output logic             USR_VALID_O,
    output logic             USR_LAST_O,
    output logic             USR_PRIO_O,
    output logic             RX_DONE_O,
    output logic             RX_ERR_O
);
    typedef enum logic {TX_IDLE, TX_BODY} tx_state_e;

    tx_state_e   tx_state;
    logic        responder;
    logic [2:0]  own_ent;
    logic [3:0]  cfg_code;
    logic        tx_conn;
    logic [7:0]  tx_hdr;
    logic        hdr_slot;
    logic [3:0]  err;
    logic [3:0]  err_clr;
    logic [3:0]  rx_code;
    logic [2:0]  rx_ent;
    logic        rx_dir;
    logic        rx_prio;
    logic [15:0] rx_cnt;
    logic [15:0] rx_len;
    logic [23:0] station;
    logic [7:0]  suite;
    logic [7:0]  reason;
    logic [7:0]  subreason;
    logic        rd_ok;
    logic [31:0] rd_mux;
    logic        map_hit;
    logic        wr_en;
    logic        acc;
    logic        hdr_rx;
    logic [3:0]  cur_code;
    logic        cur_prio;
    logic [3:0]  d_code;
    logic        ev_type;
    logic        ev_dir;
    logic        ev_suite;
    logic        ev_len;

    octet_stream_if #(.W(8)) push_s ();
    octet_stream_if #(.W(8)) pop_s ();

    // decoders for the parser; carries_ent and dir_of also serve the framer
    function automatic logic code_known(input logic [3:0] c);
        code_known = (c == CODE_A1) || (c == CODE_A2) ||
                     (c == CODE_A3) || (c == CODE_RS) ||
                     (c == CODE_UD) || (c == CODE_DC);
    endfunction

    function automatic logic carries_ent(input logic [3:0] c);
        carries_ent = (c == CODE_A1) || (c == CODE_A2);
    endfunction

    function automatic logic dir_of(input logic [3:0] c,
                                    input logic       resp);
        case (c)
            CODE_A1, CODE_A3: dir_of = 1'b0;                   // [R8] [R11]
            CODE_A2, CODE_RS: dir_of = 1'b1;                   // [R10] [R12]
            default:          dir_of = resp;
        endcase
    endfunction

    function automatic logic len_ok(input logic [3:0]  c,
                                    input logic [15:0] n);
        case (c)
            CODE_A1: len_ok = (n == LEN_A1);
            CODE_A2: len_ok = (n == LEN_A2);
            CODE_A3: len_ok = (n == LEN_A3);
            CODE_RS: len_ok = (n == LEN_RS);
            CODE_DC: len_ok = (n == LEN_DC);
            CODE_UD: len_ok = (n >= LEN_UD_MIN);
            default:  len_ok = 1'b0;
        endcase
    endfunction

    // header octet; type field forced to zero where it is reserved
    always_comb begin
        tx_hdr = 8'h00;
        if (carries_ent(cfg_code)) begin
            tx_hdr[HDR_ENT_LSB +: 3] = own_ent;                // [R7] [R17]
        end
        tx_hdr[HDR_CODE_LSB +: 4] = cfg_code;                  // [R2] [R3] [R4]
        tx_hdr[HDR_DIR_BIT] = dir_of(cfg_code, responder);     // [R6] [R8] [R10]
    end

    // the header is inserted ahead of the first body octet
    assign hdr_slot = (tx_state == TX_IDLE) && !TX_PRIO_I;    // [R1] [R5]
    assign push_s.valid = CE_I && TX_VALID_I;
    assign push_s.data  = hdr_slot ? tx_hdr : TX_DATA_I;
    assign push_s.last  = hdr_slot ? 1'b0 : TX_LAST_I;
    assign push_s.conn  = hdr_slot ? carries_ent(cfg_code)
                        : (tx_state == TX_BODY) && tx_conn;   // [R15]
    assign TX_READY_O   = push_s.ready && !hdr_slot;

    // framer sequencing
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            tx_state <= TX_IDLE;
            tx_conn  <= 1'b0;
        end else if (push_s.valid && push_s.ready) begin
            case (tx_state)
                TX_IDLE: begin
                    tx_conn <= !TX_PRIO_I && carries_ent(cfg_code);
                    if (hdr_slot || !TX_LAST_I) begin
                        tx_state <= TX_BODY;
                    end
                end
                TX_BODY: begin
                    if (TX_LAST_I) begin
                        tx_state <= TX_IDLE;
                        tx_conn  <= 1'b0;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // absorbs a transport stall without dropping an octet
    octet_buffer #(
        .W     (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .ce_i  (CE_I),
        .push  (push_s.snk),
        .pop   (pop_s.src)
    );

    assign pop_s.ready = OUT_READY_I;
    assign OUT_DATA_O  = pop_s.data;
    assign OUT_LAST_O  = pop_s.last;
    assign OUT_CONN_O  = pop_s.conn;
    assign OUT_VALID_O = pop_s.valid;

    // receive side decode; the parser never back-pressures
    assign RX_READY_O = CE_I;
    assign acc      = CE_I && RX_VALID_I;
    assign hdr_rx   = acc && (rx_cnt == '0) && !RX_PRIO_I;
    assign d_code   = RX_DATA_I[HDR_CODE_LSB +: 4];
    assign cur_code = (rx_cnt == '0) ? d_code : rx_code;
    assign cur_prio = (rx_cnt == '0) ? RX_PRIO_I : rx_prio;
    assign ev_type  = hdr_rx && !code_known(d_code);          // [R18]
    // a reflected frame shows our own direction bit
    assign ev_dir   = hdr_rx && code_known(d_code) &&
                      (RX_DATA_I[HDR_DIR_BIT] != dir_of(d_code, !responder));
    assign ev_suite = acc && !rx_prio && (rx_cnt == IDX_SUITE) &&
                      carries_ent(rx_code) && (RX_DATA_I != SUITE_SDES); // [R9]
    assign ev_len   = acc && RX_LAST_I && !cur_prio &&
                      !len_ok(cur_code, rx_cnt + 16'h0001);  // [R13] [R14] [R18]

    // frame position and header fields
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            rx_cnt  <= '0;
            rx_code <= '0;
            rx_ent  <= '0;
            rx_dir  <= 1'b0;
            rx_prio <= 1'b0;
            rx_len  <= '0;
        end else if (acc) begin
            rx_cnt <= RX_LAST_I ? '0 : rx_cnt + 16'h0001;
            if (rx_cnt == '0) begin
                rx_prio <= RX_PRIO_I;                         // [R5]
            end
            if (hdr_rx) begin
                rx_code <= d_code;                            // [R2]
                rx_dir  <= RX_DATA_I[HDR_DIR_BIT];
                // reserved type field is not looked at
                rx_ent  <= carries_ent(d_code) ?
                           RX_DATA_I[HDR_ENT_LSB +: 3] : ENT_RESERVED; // [R17]
            end
            if (RX_LAST_I) begin
                rx_len <= rx_cnt + 16'h0001;
            end
        end
    end

    // connect-frame and disconnect-frame fields
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            station   <= '0;
            suite     <= '0;
            reason    <= '0;
            subreason <= '0;
        end else if (acc && !rx_prio && rx_cnt != '0) begin
            if (carries_ent(rx_code) && rx_cnt >= IDX_ID_FIRST &&
                rx_cnt <= IDX_ID_LAST) begin
                station <= {station[15:0], RX_DATA_I};        // [R8] [R10] [R16]
            end
            if (carries_ent(rx_code) && rx_cnt == IDX_SUITE) begin
                suite <= RX_DATA_I;
            end
            if (rx_code == CODE_DC && rx_cnt == IDX_REASON) begin
                reason <= RX_DATA_I;                          // [R14]
            end
            if (rx_code == CODE_DC && rx_cnt == IDX_SUBREASON) begin
                subreason <= RX_DATA_I;
            end
        end
    end

    // body octets onward to local control, header stripped
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            USR_DATA_O  <= '0;
            USR_VALID_O <= 1'b0;
            USR_LAST_O  <= 1'b0;
            USR_PRIO_O  <= 1'b0;
            RX_DONE_O   <= 1'b0;
            RX_ERR_O    <= 1'b0;
        end else if (CE_I) begin
            USR_VALID_O <= acc && !hdr_rx;
            USR_DATA_O  <= RX_DATA_I;
            USR_LAST_O  <= acc && RX_LAST_I;
            USR_PRIO_O  <= cur_prio;
            RX_DONE_O   <= acc && RX_LAST_I;
            RX_ERR_O    <= ev_type | ev_dir | ev_suite | ev_len; // [R18]
        end
    end

    // sticky errors: a new event beats a same-cycle clear
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            err <= '0;
        end else if (CE_I) begin
            err <= (err & ~err_clr) |
                   {ev_suite, ev_dir, ev_len, ev_type};       // [R18]
        end
    end

    // apb decode; zero-wait writes, reads answer once data is latched
    assign wr_en   = CE_I && PSEL_I && PENABLE_I && PWRITE_I;
    assign err_clr = (wr_en && PADDR_I == OFS_STATUS) ? PWDATA_I[3:0] : '0;
    assign map_hit = (PADDR_I == OFS_CTRL)    || (PADDR_I == OFS_TXTYPE) ||
                     (PADDR_I == OFS_STATUS)  || (PADDR_I == OFS_RXLEN) ||
                     (PADDR_I == OFS_STATION) || (PADDR_I == OFS_RXINFO);
    assign PREADY_O  = CE_I && PSEL_I && PENABLE_I && (PWRITE_I || rd_ok);
    assign PSLVERR_O = PREADY_O && !map_hit;

    // read multiplexer; unmapped and unused bits read zero
    always_comb begin
        rd_mux = '0;
        case (PADDR_I)
            OFS_CTRL:    rd_mux[3:0]  = {own_ent, responder};
            OFS_TXTYPE:  rd_mux[3:0]  = cfg_code;
            OFS_STATUS:  rd_mux[12:0] = {(rx_cnt != '0), rx_dir, rx_ent,
                                         rx_code, err};
            OFS_RXLEN:   rd_mux[15:0] = rx_len;
            OFS_STATION: rd_mux[23:0] = station;
            OFS_RXINFO:  rd_mux[23:0] = {subreason, reason, suite};
            default:     rd_mux = '0;
        endcase
    end

    // read data latched in the setup cycle
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            PRDATA_O <= '0;
            rd_ok    <= 1'b0;
        end else if (CE_I) begin
            if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
                PRDATA_O <= rd_mux;
                rd_ok    <= 1'b1;
            end else if (PREADY_O) begin
                rd_ok <= 1'b0;
            end
        end
    end

    // configuration writes; the role is fixed per connection by software
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            responder <= 1'b0;
            own_ent   <= RST_OWN_ENT;
            cfg_code  <= RST_TXTYPE;
        end else if (wr_en) begin
            if (PADDR_I == OFS_CTRL) begin
                {own_ent, responder} <= PWDATA_I[3:0];        // [R6]
            end
            if (PADDR_I == OFS_TXTYPE) begin
                cfg_code <= PWDATA_I[3:0];
            end
        end
    end

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    a_hdr_code_tx: assert property ( // [R3]
        push_s.valid && push_s.ready && hdr_slot
        |-> push_s.data[HDR_CODE_LSB +: 4] == cfg_code)
        else $error("header type code differs from configured code");

    a_ent_reserved_zero: assert property ( // [R11]
        push_s.valid && hdr_slot && !carries_ent(cfg_code)
        |-> push_s.data[7:5] == 3'h0)
        else $error("reserved entity type field not zero");

    a_first_dir_zero: assert property ( // [R8]
        push_s.valid && hdr_slot && cfg_code == CODE_A1
        |-> !push_s.data[0])
        else $error("first auth frame sent with direction one");

    a_resp_dir_one: assert property ( // [R12]
        push_s.valid && hdr_slot && cfg_code == CODE_RS
        |-> push_s.data[0])
        else $error("auth response sent with direction zero");

    a_data_dir_role: assert property ( // [R6]
        push_s.valid && hdr_slot && cfg_code == CODE_UD
        |-> push_s.data[0] == responder)
        else $error("user-data direction bit not equal to role");

    a_conn_tag_body: assert property ( // [R15]
        push_s.valid && push_s.ready && hdr_slot && carries_ent(cfg_code)
        |=> tx_state == TX_BODY && tx_conn)
        else $error("auth frame body lost connect tag");

    a_prio_no_hdr: assert property ( // [R5]
        tx_state == TX_IDLE && TX_VALID_I && TX_PRIO_I && CE_I
        |-> push_s.data == TX_DATA_I && TX_READY_O == push_s.ready)
        else $error("priority frame given a header");

    a_type_err_flag: assert property ( // [R18]
        hdr_rx && !code_known(d_code) |=> err[ERR_TYPE] && RX_ERR_O)
        else $error("unknown type code not flagged");

    a_len_err_flag: assert property ( // [R13]
        acc && RX_LAST_I && !cur_prio && cur_code == CODE_UD &&
        rx_cnt < 16'h0009 |=> err[ERR_LEN])
        else $error("short user-data frame not flagged");

    a_done_len: assert property ( // [R1]
        acc && RX_LAST_I |=> RX_DONE_O && rx_len == $past(rx_cnt) + 16'h0001)
        else $error("received length not recorded");
endmodule
`default_nettype wire

// [secure_frame_codec_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module secure_frame_codec_tb;
    import sfc_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, pslv;
    logic [7:0]  paddr, tx_data, out_data, rx_data, usr_data;
    logic [31:0] pwdata, prdata, seed, rd;
    logic        tx_valid, tx_last, tx_prio, tx_ready, resp;
    logic        out_last, out_conn, out_valid, out_ready;
    logic        rx_valid, rx_last, rx_prio, rx_ready;
    logic        usr_valid, usr_last, usr_prio, rx_done, rx_err;
    int          err_total, comparisons, n_done, n_err;
    logic [7:0]  fr[32];
    logic [9:0]  usr_q[$];
    logic [3:0]  codes[6] = '{CODE_A1, CODE_A2, CODE_A3,
                              CODE_RS, CODE_UD, CODE_DC};
    int          lens[6] = '{LEN_A1 - 1, LEN_A2 - 1, LEN_A3 - 1,
                             LEN_RS - 1, LEN_UD_MIN - 1, LEN_DC - 1};
    secure_frame_codec dut_u (
        .REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .PADDR_I(paddr),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid),
        .TX_LAST_I(tx_last), .TX_PRIO_I(tx_prio), .TX_READY_O(tx_ready),
        .OUT_DATA_O(out_data), .OUT_LAST_O(out_last),
        .OUT_CONN_O(out_conn), .OUT_VALID_O(out_valid),
        .OUT_READY_I(out_ready), .RX_DATA_I(rx_data),
        .RX_VALID_I(rx_valid), .RX_LAST_I(rx_last), .RX_PRIO_I(rx_prio),
        .RX_READY_O(rx_ready), .USR_DATA_O(usr_data),
        .USR_VALID_O(usr_valid), .USR_LAST_O(usr_last),
        .USR_PRIO_O(usr_prio), .RX_DONE_O(rx_done), .RX_ERR_O(rx_err));
    sfc_transport_model tm_u (
        .clk_i(clk), .rst_i(rst), .data_i(out_data), .last_i(out_last),
        .conn_i(out_conn), .valid_i(out_valid), .ready_o(out_ready));
    // 20 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // collect parsed body octets and frame events
    always @(posedge clk) begin
        if (usr_valid)
            usr_q.push_back({usr_prio, usr_last, usr_data});
        n_done <= n_done + int'(rx_done);
        n_err  <= n_err + int'(rx_err);
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic hang(input string m);
        err_total++;
        $display("CHECK FAILED t=%0t wait ran out: %s", $time, m);
        report_and_stop();
    endtask
    task automatic chk(input logic [31:0] g, e, input string m);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // one apb transfer; the master never assumes the wait length
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic r;
        psel    <= 1'b1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        r = 1'b0;
        for (int k = 0; k < 20 && !r; k++) begin
            @(posedge clk);
            r = pready;
        end
        if (r !== 1'b1)
            hang("apb");
        // answer taken at the very edge that saw pready high
        pslv = pslverr;
        if (!w)
            rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic tx_byte(input logic [7:0] d, input logic l, p);
        logic r;
        tx_valid <= 1'b1;
        tx_data  <= d;
        tx_last  <= l;
        tx_prio  <= p;
        for (int k = 0; k < 50; k++) begin
            @(negedge clk);
            r = tx_ready;
            @(posedge clk);
            if (r)
                break;
        end
        if (r !== 1'b1)
            hang("tx ready");
    endtask
    // send one body and compare the framed octets seen by the far side
    task automatic tx_frame(input logic [3:0] c, input int n, input logic p);
        logic [9:0] x[$];
        logic       cn, dr;
        int         b, i;
        cn = !p && (c == CODE_A1 || c == CODE_A2);
        dr = (c == CODE_A2 || c == CODE_RS) ? 1'b1 :
             (c == CODE_A1 || c == CODE_A3) ? 1'b0 : resp;
        apb(1'b1, OFS_TXTYPE, {28'h0, c});
        b = tm_u.got.size();
        if (!p)
            x.push_back({cn, 1'b0, cn ? ENT_ENGINE : 3'h0, c, dr});
        for (i = 0; i < n; i++) begin
            seed = lfsr(seed);
            x.push_back({cn, i == n - 1, seed[7:0]});
            tx_byte(seed[7:0], i == n - 1, p);
        end
        tx_valid <= 1'b0;
        for (i = 0; i < 99 && tm_u.got.size() < b + x.size(); i++)
            @(posedge clk);
        if (i == 99)
            hang("tx drain");
        foreach (x[j])
            chk(tm_u.got[b + j], x[j], "tx octet");
    endtask
    // feed fr[0..n-1] from the transport side and check the parse
    task automatic rx_case(input int n, input logic p, input logic [3:0] eb);
        int d0, e0;
        usr_q = {};
        d0 = n_done;
        e0 = n_err;
        for (int i = 0; i < n; i++) begin
            rx_valid <= 1'b1;
            rx_data  <= fr[i];
            rx_last  <= i == n - 1;
            rx_prio  <= p;
            @(posedge clk);
        end
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~fr[n - 1];
        repeat (3) @(posedge clk);
        chk(n_err != e0, eb != 0, "rx error pulse");
        if (eb == 0) begin
            chk(n_done - d0, 1, "rx done");
            chk(usr_q.size(), n - !p, "rx count");
            foreach (usr_q[i])
                chk(usr_q[i], {p, i == n - 1 - !p, fr[i + !p]}, "rx");
        end
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd[3:0], eb, "rx error flags");
        apb(1'b1, OFS_STATUS, 32'hf);
    endtask
    initial begin
        {rst, resp} = 2'b10;
        {psel, penable, pwrite, tx_valid, tx_last, tx_prio} = '0;
        {rx_valid, rx_last, rx_prio, paddr, tx_data, rx_data} = '0;
        pwdata = 32'h0;
        seed = 32'h8b88;
        foreach (fr[i])
            fr[i] = 8'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(rd[3:0], {RST_OWN_ENT, 1'b0}, "ctrl reset");
        apb(1'b0, OFS_TXTYPE, 32'h0);
        chk(rd[3:0], RST_TXTYPE, "txtype reset");
        apb(1'b0, 8'h20, 32'h0);
        chk({pslv, rd[30:0]}, {1'b1, 31'h0}, "unmapped");
        $display("test registers done");
        foreach (codes[i])
            tx_frame(codes[i], lens[i], 1'b0);
        apb(1'b1, OFS_CTRL, 32'h5);
        resp = 1'b1;
        tx_frame(CODE_UD, 9, 1'b0);
        tx_frame(CODE_UD, 3, 1'b1);
        apb(1'b1, OFS_CTRL, 32'h4);
        resp = 1'b0;
        $display("test transmit done");
        foreach (fr[i])
            fr[i] = lfsr(seed + i) >> 3;
        {fr[0], fr[1], fr[2], fr[3], fr[4]} = 40'h2512345601;
        rx_case(LEN_A2, 1'b0, 4'h0);
        chk(rd[12:4], 9'h092, "rx header");
        apb(1'b0, OFS_STATION, 32'h0);
        chk(rd[23:0], 24'h123456, "station");
        apb(1'b0, OFS_RXINFO, 32'h0);
        chk(rd[7:0], SUITE_SDES, "suite");
        fr[4] = 8'h02;
        rx_case(LEN_A2, 1'b0, 4'h8);
        {fr[0], fr[1], fr[2]} = 24'h11a53c;
        rx_case(LEN_DC, 1'b0, 4'h0);
        apb(1'b0, OFS_RXINFO, 32'h0);
        chk(rd[23:8], 16'h3ca5, "reason");
        fr[0] = 8'heb;
        rx_case(LEN_UD_MIN, 1'b0, 4'h0);
        chk(rd[10:8], 3'h0, "rx reserved type");
        fr[0] = 8'h0a;
        rx_case(LEN_UD_MIN, 1'b0, 4'h4);
        fr[0] = 8'h1f;
        rx_case(9, 1'b0, 4'h3);
        fr[0] = 8'h13;
        rx_case(5, 1'b0, 4'h2);
        rx_case(4, 1'b1, 4'h0);
        $display("test receive done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// [sfc_pkg.sv]
// Function
// R1 - header, data field, 8-octet code trailer
// R2 - header: entity type, type code, direction
// R3 - auth frame codes 0001, 0010, 0011
// R4 - response 1001, user-data 0101, disconnect 1000
// R5 - priority frame carries no header octet
// R6 - direction: initiator sends 0, responder 1
// R7 - entity type encodes sender class
// R8 - first auth frame: identity, suite, random
// R9 - only protection suite value 0x01 used
// R10 - second auth frame: identity, suite, random, code
// R11 - third auth frame: reserved type, direction 0
// R12 - auth response: reserved type, direction 1
// R13 - user-data: n>=1 octets then code
// R14 - disconnect frame: header, reason, sub-reason
// R15 - first two auth frames use connect primitives
// R16 - octet bits 8..1, msb octet first
// R17 - reserved fields sent zero, ignored on receipt
// R18 - flag unknown type code or bad length
`default_nettype none
package sfc_pkg;
    // frame type codes
    localparam logic [3:0] CODE_A1 = 4'h1;
    localparam logic [3:0] CODE_A2 = 4'h2;
    localparam logic [3:0] CODE_A3 = 4'h3;
    localparam logic [3:0] CODE_RS = 4'h9;
    localparam logic [3:0] CODE_UD = 4'h5;
    localparam logic [3:0] CODE_DC = 4'h8;
    // sender classes
    localparam logic [2:0] ENT_INFILL  = 3'h0;
    localparam logic [2:0] ENT_TRACKSIDE_BLOCK_CONTROLLER = 3'h1;
    localparam logic [2:0] ENT_ENGINE  = 3'h2;
    localparam logic [2:0] ENT_RESERVED = 3'h0;
    localparam logic [7:0] SUITE_SDES  = 8'h01;
    // header field positions (bit 8 of the octet is index 7)
    localparam int HDR_ENT_LSB  = 5;
    localparam int HDR_CODE_LSB = 1;
    localparam int HDR_DIR_BIT  = 0;
    // frame lengths in octets
    localparam logic [15:0] LEN_A1     = 16'h000d;
    localparam logic [15:0] LEN_A2     = 16'h0015;
    localparam logic [15:0] LEN_A3     = 16'h0009;
    localparam logic [15:0] LEN_RS     = 16'h0009;
    localparam logic [15:0] LEN_DC     = 16'h0003;
    localparam logic [15:0] LEN_UD_MIN = 16'h000a;
    // octet indexes, counted from zero at the header
    localparam logic [15:0] IDX_ID_FIRST = 16'h0001;
    localparam logic [15:0] IDX_ID_LAST  = 16'h0003;
    localparam logic [15:0] IDX_SUITE    = 16'h0004;
    localparam logic [15:0] IDX_REASON   = 16'h0001;
    localparam logic [15:0] IDX_SUBREASON = 16'h0002;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TXTYPE  = 8'h04;
    localparam logic [7:0] OFS_STATUS  = 8'h08;
    localparam logic [7:0] OFS_RXLEN   = 8'h0c;
    localparam logic [7:0] OFS_STATION = 8'h10;
    localparam logic [7:0] OFS_RXINFO  = 8'h14;
    // register reset values
    localparam logic [3:0] RST_TXTYPE  = CODE_UD;
    localparam logic [2:0] RST_OWN_ENT = ENT_ENGINE;
    // sticky error bit positions in the status register
    localparam int ERR_TYPE  = 0;
    localparam int ERR_LEN   = 1;
    localparam int ERR_DIR   = 2;
    localparam int ERR_SUITE = 3;
endpackage
`default_nettype wire

// [sfc_transport_model.sv]
`timescale 1ns/1ns
`default_nettype none
// transport side: takes framed octets with an uneven ready pattern
module sfc_transport_model (
    // clock, reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // framed octets from the codec
    input  wire logic [7:0] data_i,
    input  wire logic       last_i,
    input  wire logic       conn_i,
    input  wire logic       valid_i,
    output logic            ready_o
);
    logic [9:0] got[$];
    logic [2:0] cnt;
    // stall three beats in eight so the two-entry buffer really fills
    always @(posedge clk_i) begin
        cnt     <= rst_i ? 3'h0 : cnt + 3'h1;
        ready_o <= !rst_i && (cnt % 3 != 0);
        if (valid_i && ready_o)
            got.push_back({conn_i, last_i, data_i});
    end
endmodule
`default_nettype wire
